// file: inc/acc_pkg.sv
package acc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] ACC_IDX_CTRL = 12'hF70;
    localparam logic [11:0] ACC_IDX_RAW = 12'hF71;
    localparam logic [11:0] ACC_IDX_HIGH = 12'hF72;
    localparam logic [11:0] ACC_IDX_LOW = 12'hF73;
    // Control and low result register field positions
    localparam int ACC_START_BIT = 7;
    localparam int ACC_IREF_BIT = 6;
    localparam int ACC_RSRC_BIT = 5;
    localparam int ACC_EN_BIT = 4;
    localparam int ACC_CH_LSB = 0;
    localparam int ACC_CH_W = 4;
    localparam int ACC_LOW_LSB = 6;
    // Reset values
    localparam logic [6:0] ACC_CTRL_RST = 7'h00;
    localparam logic [7:0] ACC_RES_RST = 8'h00;
    // Channel codes beyond the eight plain inputs
    localparam logic [3:0] ACC_CH_GND_AMP = 4'h8;
    localparam logic [3:0] ACC_CH_TEMP = 4'h9;
    localparam logic [3:0] ACC_CH_TEMP_PAD = 4'hC;
    localparam logic [3:0] ACC_CH_BGCHOP_PAD = 4'hD;
    // Timing: clock period, phase times, derived and fixed cycle counts; result width
    localparam int ACC_CLK_NS = 40;
    localparam int ACC_SAMPLE_NS = 1800;
    localparam int ACC_SETTLE_NS = 500;
    localparam int ACC_SAMPLE_CYC = (ACC_SAMPLE_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;
    localparam int ACC_SETTLE_CYC = (ACC_SETTLE_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;
    localparam int ACC_CONV_CYC = 13;
    localparam int ACC_RES_W = 10;
    // AXI responses
    localparam logic [1:0] ACC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic internal_reference_choice;
        logic reference_source_select;
        logic converter_enable;
        logic [3:0] input_channel_select;
    } acc_ctrl_t;

    typedef struct packed {
        logic [7:0] ana_select;
        logic ground_amp_inputs;
        logic temp_sensor_select;
        logic temp_to_pad;
        logic bgchop_to_pad;
    } acc_route_t;

    typedef enum logic [3:0] {
        ACC_S_IDLE = 4'h1,
        ACC_S_SAMPLE = 4'h2,
        ACC_S_SETTLE = 4'h4,
        ACC_S_CONVERT = 4'h8
    } acc_state_t;
endpackage

// file: src/acc_chan_route.sv
`timescale 1ns/1ps
module acc_chan_route
    import acc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] code,
    output acc_route_t route
);
    acc_route_t route_reg;

    function automatic acc_route_t acc_decode(input logic [3:0] c);
        acc_route_t r;
        r = '0;
        if (!c[3]) begin
            r.ana_select = 8'h01 << c[2:0];
        end
        r.ground_amp_inputs = (c == ACC_CH_GND_AMP);
        r.temp_sensor_select = (c == ACC_CH_TEMP);
        r.temp_to_pad = (c == ACC_CH_TEMP_PAD);
        r.bgchop_to_pad = (c == ACC_CH_BGCHOP_PAD);
        return r;
    endfunction

    // Registered so the mux controls never glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            route_reg <= '0;
        end else begin
            route_reg <= acc_decode(code);
        end
    end

    assign route = route_reg;

    a_route_plain: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && !code[3] |=> route.ana_select == (8'h01 << $past(code[2:0])))
        else $error("plain channel not routed");
    a_route_ground: assert property (@(posedge aclk) disable iff (!aresetn)
        code == ACC_CH_GND_AMP |=> route.ground_amp_inputs && route.ana_select == 8'h00)
        else $error("amplifier nodes not grounded");
endmodule // acc_chan_route

// file: src/acc_sar_seq.sv
`timescale 1ns/1ps
module acc_sar_seq
    import acc_pkg::*;
#(
    parameter int SAMPLE_CYC = ACC_SAMPLE_CYC,
    parameter int SETTLE_CYC = ACC_SETTLE_CYC,
    parameter int CONV_CYC = ACC_CONV_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    input wire logic enable,
    input wire logic cmp_in,
    output logic busy,
    output logic sample_hold,
    output logic [ACC_RES_W-1:0] sar_value,
    output logic [ACC_RES_W-1:0] result,
    output logic done
);
    acc_state_t state_reg;
    logic [7:0] cnt_reg;
    logic [ACC_RES_W-1:0] sar_reg;
    logic [ACC_RES_W-1:0] result_reg;
    logic done_reg;

    initial begin
        if (CONV_CYC < ACC_RES_W || CONV_CYC > 255 || SAMPLE_CYC < 1 || SAMPLE_CYC > 255
            || SETTLE_CYC < 1 || SETTLE_CYC > 255) begin
            $error("acc_sar_seq: phase counts out of range");
        end
    end

    // Phase sequencing; a start restarts from sampling unless enable is low, which forces idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ACC_S_IDLE;
            cnt_reg <= 8'h00;
        end else if (!enable) begin
            state_reg <= ACC_S_IDLE;
            cnt_reg <= 8'h00;
        end else if (start) begin
            state_reg <= ACC_S_SAMPLE;
            cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                ACC_S_SAMPLE: begin
                    cnt_reg <= (cnt_reg == 8'(SAMPLE_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
                    if (cnt_reg == 8'(SAMPLE_CYC - 1)) state_reg <= ACC_S_SETTLE;
                end
                ACC_S_SETTLE: begin
                    cnt_reg <= (cnt_reg == 8'(SETTLE_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
                    if (cnt_reg == 8'(SETTLE_CYC - 1)) state_reg <= ACC_S_CONVERT;
                end
                ACC_S_CONVERT: begin
                    cnt_reg <= (cnt_reg == 8'(CONV_CYC - 1)) ? 8'h00 : cnt_reg + 8'h01;
                    if (cnt_reg == 8'(CONV_CYC - 1)) state_reg <= ACC_S_IDLE;
                end
                default: begin
                    state_reg <= ACC_S_IDLE;
                    cnt_reg <= 8'h00;
                end
            endcase
        end
    end

    // Successive approximation, MSB first, one bit per cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sar_reg <= '0;
        end else if (state_reg == ACC_S_SETTLE) begin
            sar_reg <= {1'b1, {(ACC_RES_W - 1){1'b0}}};
        end else if (state_reg == ACC_S_CONVERT && cnt_reg < 8'(ACC_RES_W)) begin
            for (int i = 0; i < ACC_RES_W; i++) begin
                // Decide this bit, and raise the next trial bit one step earlier
                if (8'(ACC_RES_W - 1 - i) == cnt_reg) begin
                    sar_reg[i] <= cmp_in;
                end
                if (8'(ACC_RES_W - 2 - i) == cnt_reg) begin
                    sar_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Result capture and completion pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= enable && !start && state_reg == ACC_S_CONVERT
                && cnt_reg == 8'(CONV_CYC - 1);
            if (enable && !start && state_reg == ACC_S_CONVERT
                && cnt_reg == 8'(CONV_CYC - 1)) begin
                result_reg <= sar_reg;
            end
        end
    end

    assign busy = (state_reg != ACC_S_IDLE);
    assign sample_hold = state_reg[1]; // Sampling bit of the one-hot state, a flop
    assign sar_value = sar_reg;
    assign result = result_reg;
    assign done = done_reg;

    a_start_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        start && enable |=> state_reg == ACC_S_SAMPLE && cnt_reg == 8'h00)
        else $error("start did not restart sampling");
    a_conv_length: assert property (@(posedge aclk) disable iff (!aresetn)
        done_reg |-> $past(state_reg) == ACC_S_CONVERT && $past(cnt_reg) == 8'(CONV_CYC - 1))
        else $error("conversion length wrong");
    a_disable_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !busy && !done_reg)
        else $error("disabled converter still busy");
endmodule // acc_sar_seq

// file: src/acc_regs.sv
`timescale 1ns/1ps
module acc_regs
    import acc_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int SAMPLE_CYC = ACC_SAMPLE_CYC,
    parameter int SETTLE_CYC = ACC_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmp_in,
    output logic [ACC_RES_W-1:0] sar_trial,
    output logic sample_hold,
    output logic converter_enable,
    output logic reference_source_select,
    output logic internal_reference_choice,
    output acc_route_t route,
    output logic conv_done_req
);
    initial begin
        if (ADDR_W < 14) begin
            $error("acc_regs: ADDR_W must reach the register indices");
        end
    end

    // Word index of a byte address
    function automatic logic [11:0] acc_index(input logic [ADDR_W-1:0] a);
        return a[13:2];
    endfunction

    function automatic logic acc_mapped(input logic [ADDR_W-1:0] a);
        logic [11:0] i;
        i = acc_index(a);
        return ((a >> 14) == '0) && i >= ACC_IDX_CTRL && i <= ACC_IDX_LOW;
    endfunction

    // Write channel state
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    // Read channel state
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    // Block state
    acc_ctrl_t ctrl_reg;
    logic [7:0] high_reg;
    logic [1:0] low_pair_reg;
    logic [7:0] low_reg;
    // Submodule wires
    logic busy;
    logic conv_done;
    logic [ACC_RES_W-1:0] sar_value;
    logic [ACC_RES_W-1:0] result;

    // Write handshake bookkeeping; address and data may come in either order
    logic aw_fire;
    logic w_fire;
    logic wr_do;
    logic aw_hold_next;
    logic w_hold_next;
    logic bvalid_next;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic ctrl_wr;
    logic start_req;
    assign aw_fire = s_axi_awvalid && awready_reg;
    assign w_fire = s_axi_wvalid && wready_reg;
    assign wr_do = (aw_hold_reg || aw_fire) && (w_hold_reg || w_fire);
    assign aw_hold_next = (aw_hold_reg || aw_fire) && !wr_do;
    assign w_hold_next = (w_hold_reg || w_fire) && !wr_do;
    assign bvalid_next = wr_do || (bvalid_reg && !s_axi_bready);
    assign wr_addr = aw_fire ? s_axi_awaddr : awaddr_reg;
    assign wr_data = w_fire ? s_axi_wdata : wdata_reg;
    assign wr_strb = w_fire ? s_axi_wstrb : wstrb_reg;
    assign ctrl_wr = wr_do && acc_mapped(wr_addr) && acc_index(wr_addr) == ACC_IDX_CTRL
        && wr_strb[0];
    // Start only on a written one; enable must already be set beforehand
    assign start_req = ctrl_wr && wr_data[ACC_START_BIT];

    // Write address, data and response registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ACC_RESP_OKAY;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            bvalid_reg <= bvalid_next;
            awready_reg <= !aw_hold_next && !bvalid_next;
            wready_reg <= !w_hold_next && !bvalid_next;
            if (aw_fire) awaddr_reg <= s_axi_awaddr;
            if (w_fire) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                bresp_reg <= acc_mapped(wr_addr) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            end
        end
    end

    // Control register; writes to result registers fall through unused
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= ACC_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg.internal_reference_choice <= wr_data[ACC_IREF_BIT];
            ctrl_reg.reference_source_select <= wr_data[ACC_RSRC_BIT];
            ctrl_reg.converter_enable <= wr_data[ACC_EN_BIT];
            ctrl_reg.input_channel_select <= wr_data[ACC_CH_LSB +: ACC_CH_W];
        end
    end

    // Read handshake
    logic ar_fire;
    logic high_rd;
    logic [11:0] rd_idx;
    logic [7:0] rd_byte;
    assign ar_fire = s_axi_arvalid && arready_reg;
    assign rd_idx = acc_index(s_axi_araddr);
    assign high_rd = ar_fire && acc_mapped(s_axi_araddr) && rd_idx == ACC_IDX_HIGH;

    // Read data multiplexer
    always_comb begin
        rd_byte = 8'h00;
        case (rd_idx)
            ACC_IDX_CTRL: rd_byte = {busy, ctrl_reg};
            ACC_IDX_RAW: rd_byte = sar_value[ACC_RES_W-1 -: 8];
            ACC_IDX_HIGH: rd_byte = high_reg;
            ACC_IDX_LOW: rd_byte = low_reg;
            default: rd_byte = 8'h00;
        endcase
        if (!acc_mapped(s_axi_araddr)) rd_byte = 8'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= ACC_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            rvalid_reg <= ar_fire || (rvalid_reg && !s_axi_rready);
            arready_reg <= !(ar_fire || (rvalid_reg && !s_axi_rready));
            if (ar_fire) begin
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= acc_mapped(s_axi_araddr) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            end
        end
    end

    // Results: high byte held to the next completion, pair waits for a high read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_reg <= ACC_RES_RST;
            low_pair_reg <= 2'h0;
        end else if (conv_done) begin
            high_reg <= result[ACC_RES_W-1:2];
            low_pair_reg <= result[1:0];
        end
    end

    // Low pair copied only on a high byte read, so both belong together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_reg <= ACC_RES_RST;
        end else if (high_rd) begin
            low_reg <= {low_pair_reg, {ACC_LOW_LSB{1'b0}}};
        end
    end

    acc_sar_seq #(
        .SAMPLE_CYC(SAMPLE_CYC),
        .SETTLE_CYC(SETTLE_CYC),
        .CONV_CYC(ACC_CONV_CYC)
    ) u_seq (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start_req),
        .enable(ctrl_reg.converter_enable),
        .cmp_in(cmp_in),
        .busy(busy),
        .sample_hold(sample_hold),
        .sar_value(sar_value),
        .result(result),
        .done(conv_done)
    );

    acc_chan_route u_route (
        .aclk(aclk),
        .aresetn(aresetn),
        .code(ctrl_reg.input_channel_select),
        .route(route)
    );

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign sar_trial = sar_value;
    assign converter_enable = ctrl_reg.converter_enable;
    assign reference_source_select = ctrl_reg.reference_source_select;
    assign internal_reference_choice = ctrl_reg.internal_reference_choice;
    assign conv_done_req = conv_done;

    sequence s_high_read;
        high_rd;
    endsequence
    sequence s_start_write;
        start_req && ctrl_reg.converter_enable;
    endsequence

    a_start_busy: assert property (@(posedge aclk) disable iff (!aresetn)
        s_start_write |=> busy [*2])
        else $error("busy not set after start");
    a_zero_no_start: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr && !wr_data[ACC_START_BIT] && !busy |=> !busy)
        else $error("zero start launched a conversion");
    a_low_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        s_high_read |=> low_reg[7:ACC_LOW_LSB] == $past(low_pair_reg))
        else $error("low pair not latched on high read");
    a_low_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        low_reg[ACC_LOW_LSB-1:0] == 6'h00)
        else $error("low reserved bits not zero");
    a_high_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        !conv_done |=> $stable(high_reg))
        else $error("high byte moved without completion");
    a_done_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !start_req |-> !busy ##1 high_reg == $past(result[ACC_RES_W-1:2]))
        else $error("completion did not load result");
    a_ref_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_wr |=> reference_source_select == $past(wr_data[ACC_RSRC_BIT])
        && internal_reference_choice == $past(wr_data[ACC_IREF_BIT]))
        else $error("reference bits not stored");
endmodule // acc_regs

// file: dv/acc_sar_model.sv
`timescale 1ns/1ps
// Comparator and input mux on the far side of the converter
module acc_sar_model
    import acc_pkg::*;
(
    input wire logic [ACC_RES_W-1:0] sar_trial,
    input acc_route_t route,
    output logic cmp_in
);
    logic [ACC_RES_W-1:0] chan_val [8];
    logic [ACC_RES_W-1:0] temp_val = 10'h155; // Arbitrary sensor level
    logic [ACC_RES_W-1:0] level;

    // Level of the routed input; nothing routed reads as ground
    always_comb begin
        level = route.temp_sensor_select ? temp_val : 10'h000;
        for (int i = 0; i < 8; i++) begin
            if (route.ana_select[i]) begin
                level = chan_val[i];
            end
        end
    end

    // Keep the trial bit while the trial word does not overshoot
    assign cmp_in = (sar_trial <= level);
endmodule // acc_sar_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import acc_pkg::*;
;
    localparam int S = 2;
    localparam int T = 2;
    localparam logic [1:0] OK = ACC_RESP_OKAY;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [13:0] awaddr = '0;
    logic [13:0] araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid, cmp_in, en, rsrc, iref, done, sh;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [9:0] trial;
    logic [9:0] last_v = '0;
    acc_route_t route;
    int n_errors = 0;
    int num_checks = 0;
    int n_done = 0;
    int cyc = 0;
    int done_cyc = 0;
    int sh_cyc = 0;

    acc_regs #(.SAMPLE_CYC(S), .SETTLE_CYC(T)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmp_in(cmp_in), .sar_trial(trial), .sample_hold(sh),
        .converter_enable(en), .reference_source_select(rsrc),
        .internal_reference_choice(iref), .route(route), .conv_done_req(done)
    );

    acc_sar_model u_model (.sar_trial(trial), .route(route), .cmp_in(cmp_in));

    always #20 aclk = ~aclk;

    // Cycles from the start write to the completion pulse, and sampling cycles
    always @(posedge aclk) begin
        if (done === 1'b1) begin
            done_cyc = cyc;
            n_done++;
        end
        if (wvalid && wready && wdata[7]) begin
            cyc = 0;
            sh_cyc = 0;
        end else begin
            cyc++;
            if (sh === 1'b1) sh_cyc++;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] eresp);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wvalid <= 1'b1;
        wstrb <= 4'hF;
        bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (!a_ok && awready === 1'b1) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        chk({30'h0, bresp}, {30'h0, eresp});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] eresp);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, eresp});
        rready <= 1'b0;
    endtask

    function automatic acc_route_t exp_route(input logic [3:0] c);
        acc_route_t r;
        r = '0;
        if (c < 4'h8) begin
            r.ana_select[c[2:0]] = 1'b1;
        end
        r.ground_amp_inputs = (c == ACC_CH_GND_AMP);
        r.temp_sensor_select = (c == ACC_CH_TEMP);
        r.temp_to_pad = (c == ACC_CH_TEMP_PAD);
        r.bgchop_to_pad = (c == ACC_CH_BGCHOP_PAD);
        return r;
    endfunction

    // One conversion; mode 1 writes start zero midway, mode 2 restarts on a new level
    task automatic conv(input logic [2:0] ch, input logic [9:0] v, input int mode);
        int k;
        u_model.chan_val[ch] = v;
        wr(ACC_IDX_CTRL, {5'h02, ch}, OK);
        k = n_done;
        wr(ACC_IDX_CTRL, {5'h12, ch}, OK);
        rd(ACC_IDX_CTRL, {24'h0, 5'h12, ch}, OK);
        if (mode == 1) begin
            wr(ACC_IDX_CTRL, {5'h02, ch}, OK);
        end
        if (mode == 2) begin
            v = ~v;
            u_model.chan_val[ch] = v;
            wr(ACC_IDX_CTRL, {5'h12, ch}, OK);
        end
        while (n_done == k) @(posedge aclk);
        chk(done_cyc, S + T + ACC_CONV_CYC);
        chk(sh_cyc, S);
        rd(ACC_IDX_CTRL, {24'h0, 5'h02, ch}, OK);
        rd(ACC_IDX_RAW, {24'h0, v[9:2]}, OK);
        rd(ACC_IDX_LOW, {24'h0, last_v[1:0], 6'h00}, OK);
        rd(ACC_IDX_HIGH, {24'h0, v[9:2]}, OK);
        rd(ACC_IDX_LOW, {24'h0, v[1:0], 6'h00}, OK);
        last_v = v;
        chk(n_done - k, 1);
    endtask

    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] d;
        void'($urandom(71));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(ACC_IDX_CTRL, 32'h0, OK);
        rd(ACC_IDX_LOW, 32'h0, OK);
        // Start while disabled must stay idle
        wr(ACC_IDX_CTRL, 8'h80, OK);
        rd(ACC_IDX_CTRL, 32'h0, OK);
        // Every channel code with random reference bits
        for (int c = 0; c < 16; c++) begin
            d = {1'b0, 2'($urandom), 1'b1, 4'(c)};
            wr(ACC_IDX_CTRL, d, OK);
            rd(ACC_IDX_CTRL, {24'h0, d}, OK);
            chk({29'h0, iref, rsrc, en}, {29'h0, d[6:4]});
            chk({20'h0, route}, {20'h0, exp_route(4'(c))});
        end
        // Extremes first, then random levels in all three modes
        conv(3'h0, 10'h3FF, 0);
        conv(3'h7, 10'h000, 0);
        for (int i = 0; i < 9; i++) begin
            conv(3'($urandom), 10'($urandom), i % 3);
        end
        // Result registers ignore writes
        wr(ACC_IDX_RAW, 8'hFF, OK);
        wr(ACC_IDX_HIGH, 8'hFF, OK);
        wr(ACC_IDX_LOW, 8'hFF, OK);
        rd(ACC_IDX_HIGH, {24'h0, last_v[9:2]}, OK);
        rd(ACC_IDX_LOW, {24'h0, last_v[1:0], 6'h00}, OK);
        // Unmapped place answers with an error
        wr(12'hF74, 8'h12, ACC_RESP_SLVERR);
        rd(12'hF74, 32'h0, ACC_RESP_SLVERR);
        report_and_stop;
    end

    // Watchdog well beyond the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        report_and_stop;
    end
endmodule // tb_top
